//--- inc/afc_map.svh
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH
// ----------------------------------------
// register offsets (7-bit address)
// ----------------------------------------
`define AFC_OFS_RESET 7'h00
`define AFC_OFS_OUTMODE 7'h03
`define AFC_OFS_FORMAT 7'h04
`define AFC_RST_VAL 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define AFC_RESET_BIT 7
`define AFC_STD_LSB 0
`define AFC_DIS_BIT 2
`define AFC_TERM_BIT 3
`define AFC_DRV_LSB 4
`define AFC_COD_BIT 0
`define AFC_RANDOMIZER_EN_BIT 1
`define AFC_ABP_BIT 2
`define AFC_TP_LSB 3
`define AFC_OUTMODE_MASK 8'h7f
`define AFC_FORMAT_MASK 8'h3f
`define AFC_WORD_BITS 16
`define AFC_CNT_W 5
`endif

//--- inc/afc_pkg.sv
package afc_pkg;
	typedef enum logic [1:0] {
		AFC_STD_CMOS = 2'h0,
		AFC_STD_DDR_LVDS = 2'h1,
		AFC_STD_DDR_CMOS = 2'h2
	} afc_std_t;
	typedef enum logic [2:0] {
		AFC_TP_OFF = 3'h0,
		AFC_TP_ZERO = 3'h1,
		AFC_TP_ONE = 3'h3,
		AFC_TP_CHECK = 3'h5,
		AFC_TP_TOGGLE = 3'h7
	} afc_tp_t;
	typedef logic [12:0] afc_word_t;
endpackage : afc_pkg

//--- rtl/afc_output_format_config.sv
`timescale 1ns/1ps
`include "afc_map.svh"
module afc_output_format_config (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial configuration port
	input wire logic csN,
	input wire logic sck,
	input wire logic sdi,
	output logic sdoOut,
	output logic sdoOe,
	// converter samples, overflow in bit 12
	input wire logic sampleEn,
	input wire afc_pkg::afc_word_t sampleCh1,
	input wire afc_pkg::afc_word_t sampleCh2,
	// formatted outputs
	output afc_pkg::afc_word_t dataCh1,
	output afc_pkg::afc_word_t dataCh2,
	output logic dataOe,
	// output driver controls
	output afc_pkg::afc_std_t outputStandardSel,
	output logic [2:0] driveCurrentSel,
	output logic internalTermEn,
	output logic currentDouble,
	output logic [4:0] lvdsCurrentQuarterMa,
	output logic swResetPulse
);
	import afc_pkg::*;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] outputModeControl_q;
	logic [7:0] dataFormatControl_q;
	logic [7:0] outputModeControl_d;
	logic [7:0] dataFormatControl_d;
	logic [6:0] regAddr;
	logic [7:0] wrData;
	logic wrStrobe;
	logic [7:0] rdData;
	logic swReset;
	logic hitMode;
	logic hitFormat;

	afc_serial_port uPort (
		.clk(clk),
		.sys_rst(sys_rst),
		.csN(csN),
		.sck(sck),
		.sdi(sdi),
		.sdoOut(sdoOut),
		.sdoOe(sdoOe),
		.regAddr(regAddr),
		.wrData(wrData),
		.wrStrobe(wrStrobe),
		.rdData(rdData)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign swReset = wrStrobe & regAddr == `AFC_OFS_RESET &
		wrData[`AFC_RESET_BIT];
	assign hitMode = wrStrobe & regAddr == `AFC_OFS_OUTMODE;
	assign hitFormat = wrStrobe & regAddr == `AFC_OFS_FORMAT;
	assign outputModeControl_d = swReset ? `AFC_RST_VAL :
		hitMode ? (wrData & `AFC_OUTMODE_MASK) : outputModeControl_q;
	assign dataFormatControl_d = swReset ? `AFC_RST_VAL :
		hitFormat ? (wrData & `AFC_FORMAT_MASK) : dataFormatControl_q;
	assign rdData = (regAddr == `AFC_OFS_OUTMODE) ? outputModeControl_q :
		(regAddr == `AFC_OFS_FORMAT) ? dataFormatControl_q : 8'h00;
	assign swResetPulse = swReset;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			outputModeControl_q <= `AFC_RST_VAL;
			dataFormatControl_q <= `AFC_RST_VAL;
		end else begin
			outputModeControl_q <= outputModeControl_d;
			dataFormatControl_q <= dataFormatControl_d;
		end
	end

	// ----------------------------------------
	// output driver fields
	// ----------------------------------------
	assign outputStandardSel =
		afc_std_t'(outputModeControl_q[`AFC_STD_LSB +: 2]);
	assign driveCurrentSel = outputModeControl_q[`AFC_DRV_LSB +: 3];
	assign internalTermEn = outputModeControl_q[`AFC_TERM_BIT];
	assign currentDouble = internalTermEn;
	// host should also nap both channels while this is set
	assign dataOe = ~outputModeControl_q[`AFC_DIS_BIT];

	// nominal current in 0.25 mA steps before doubling (2.0 -> 8)
	function automatic logic [4:0] afc_current(input logic [2:0] sel);
		unique case (sel)
			3'h0: afc_current = 5'h0e;
			3'h1: afc_current = 5'h10;
			3'h2: afc_current = 5'h12;
			3'h4: afc_current = 5'h0c;
			3'h5: afc_current = 5'h0a;
			3'h6: afc_current = 5'h08;
			3'h7: afc_current = 5'h07;
			default: afc_current = 5'h0e;
		endcase
	endfunction : afc_current
	assign lvdsCurrentQuarterMa = afc_current(driveCurrentSel);

	// ----------------------------------------
	// per-channel formatting
	// ----------------------------------------
	afc_pattern_gen uCh1 (
		.clk(clk),
		.sys_rst(sys_rst),
		.sampleEn(sampleEn),
		.patSel(afc_tp_t'(dataFormatControl_q[`AFC_TP_LSB +: 3])),
		.coding_select(dataFormatControl_q[`AFC_COD_BIT]),
		.altPolarity(dataFormatControl_q[`AFC_ABP_BIT]),
		.randomize(dataFormatControl_q[`AFC_RANDOMIZER_EN_BIT]),
		.sampleIn(sampleCh1),
		.wordOut(dataCh1)
	);

	afc_pattern_gen uCh2 (
		.clk(clk),
		.sys_rst(sys_rst),
		.sampleEn(sampleEn),
		.patSel(afc_tp_t'(dataFormatControl_q[`AFC_TP_LSB +: 3])),
		.coding_select(dataFormatControl_q[`AFC_COD_BIT]),
		.altPolarity(dataFormatControl_q[`AFC_ABP_BIT]),
		.randomize(dataFormatControl_q[`AFC_RANDOMIZER_EN_BIT]),
		.sampleIn(sampleCh2),
		.wordOut(dataCh2)
	);
endmodule : afc_output_format_config

//--- rtl/afc_pattern_gen.sv
`timescale 1ns/1ps
// output word formatter for one channel
module afc_pattern_gen (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sampleEn,
	input wire afc_pkg::afc_tp_t patSel,
	input wire logic coding_select,
	input wire logic altPolarity,
	input wire logic randomize,
	input wire afc_pkg::afc_word_t sampleIn,
	output afc_pkg::afc_word_t wordOut
);
	import afc_pkg::*;
	logic phase_q;
	logic [11:0] coded;
	logic [11:0] polar;
	logic [11:0] rnd;
	afc_word_t live;
	afc_word_t pat;

	// abp forces offset binary
	assign coded = (coding_select & ~altPolarity) ?
		{~sampleIn[11], sampleIn[10:0]} : sampleIn[11:0];
	assign polar = altPolarity ? coded ^ 12'haaa : coded;
	assign rnd = randomize ? {polar[11:1] ^ {11{polar[0]}}, polar[0]} :
		polar;
	assign live = {sampleIn[12], rnd};
	assign pat = (patSel == AFC_TP_ZERO) ? 13'h0000 :
		(patSel == AFC_TP_ONE) ? 13'h1fff :
		(patSel == AFC_TP_CHECK) ? (phase_q ? 13'h0aaa : 13'h1555) :
		(patSel == AFC_TP_TOGGLE) ? {13{phase_q}} : 13'h0000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_q <= 1'b0;
			wordOut <= 13'h0000;
		end else if (sampleEn) begin
			phase_q <= ~phase_q;
			wordOut <= (patSel == AFC_TP_OFF) ? live : pat;
		end
	end
endmodule : afc_pattern_gen

//--- rtl/afc_serial_port.sv
`timescale 1ns/1ps
`include "afc_map.svh"
// 16-bit serial frame receiver, read-back shifter
module afc_serial_port (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial pins, sampled on clk
	input wire logic csN,
	input wire logic sck,
	input wire logic sdi,
	output logic sdoOut,
	output logic sdoOe,
	// register side
	output logic [6:0] regAddr,
	output logic [7:0] wrData,
	output logic wrStrobe,
	input wire logic [7:0] rdData
);
	logic sckPrev_q;
	logic [`AFC_CNT_W-1:0] bitCnt_q;
	logic [15:0] shift_q;
	logic [7:0] rdShift_q;
	logic [7:0] rdNext;
	logic isRead_q;
	logic done_q;
	logic sckRise;
	logic sckFall;
	logic active;
	logic full;

	assign sckRise = sck & ~sckPrev_q;
	assign sckFall = ~sck & sckPrev_q;
	assign active = ~csN;
	assign full = bitCnt_q == `AFC_CNT_W'(`AFC_WORD_BITS);
	// address sits low in the shifter when exactly 8 bits are in, high otherwise
	assign regAddr = (bitCnt_q == `AFC_CNT_W'(8)) ? shift_q[6:0] :
		shift_q[14:8];
	// first data-phase fall takes the addressed register
	assign rdNext = (bitCnt_q == `AFC_CNT_W'(8)) ? rdData : rdShift_q;
	assign wrData = shift_q[7:0];
	// open drain: drive low only
	assign sdoOut = 1'b0;

	always_ff @(posedge clk) begin
		sckPrev_q <= sck;
		wrStrobe <= 1'b0;
		if (sys_rst | ~active) begin
			// write commits when the frame closes after 16 bits
			wrStrobe <= ~sys_rst & active == 1'b0 & done_q & ~isRead_q;
			bitCnt_q <= '0;
			done_q <= 1'b0;
			sdoOe <= 1'b0;
		end else if (sckRise & ~full) begin
			shift_q <= {shift_q[14:0], sdi};
			bitCnt_q <= bitCnt_q + `AFC_CNT_W'(1);
			if (bitCnt_q == `AFC_CNT_W'(0))
				isRead_q <= sdi;
			if (bitCnt_q == `AFC_CNT_W'(`AFC_WORD_BITS - 1))
				done_q <= 1'b1;
		end else if (sckFall & isRead_q & bitCnt_q >= `AFC_CNT_W'(8) &
			~full) begin
			sdoOe <= ~rdNext[7];
			rdShift_q <= {rdNext[6:0], 1'b0};
		end
	end
endmodule : afc_serial_port

//--- testbench/afc_host_model.sv
`timescale 1ns/1ps
module afc_host_model (
	// clock
	input wire logic clk,
	// serial pins
	output logic csN,
	output logic sck,
	output logic sdi,
	input wire logic sdoOe
);
	// sdo has a pull-up, device only pulls low
	wire sdoLine = sdoOe ? 1'h0 : 1'h1;
	initial begin
		csN = 1'h1;
		sck = 1'h0;
		sdi = 1'h0;
	end
	task xfer(input logic [15:0] w, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge clk);
		csN = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			sdi = w[i];
			repeat (4) @(negedge clk);
			if (i < 8) rd[i] = sdoLine;
			sck = 1'h1;
			repeat (4) @(negedge clk);
			sck = 1'h0;
		end
		repeat (4) @(negedge clk);
		csN = 1'h1;
		sdi = ~sdi;
		repeat (4) @(negedge clk);
	endtask : xfer
endmodule : afc_host_model

//--- testbench/afc_output_format_config_bench.sv
`timescale 1ns/1ps
module afc_output_format_config_bench;
	import afc_pkg::*;
	logic clk, sys_rst, sampleEn, took, sdoOut, sdoOe, dataOe, csN, sck, sdi;
	logic currentDouble, internalTermEn, swResetPulse;
	afc_word_t sampleCh1, sampleCh2, dataCh1, dataCh2;
	afc_std_t outputStandardSel;
	logic [2:0] driveCurrentSel;
	logic [4:0] lvdsCurrentQuarterMa;
	logic [7:0] r;
	logic [5:0] tab [8] = '{6'h00, 6'h01, 6'h02, 6'h05, 6'h09, 6'h19, 6'h29,
		6'h39};
	logic [4:0] cur [8] = '{5'h0e, 5'h10, 5'h12, 5'h00, 5'h0c, 5'h0a, 5'h08,
		5'h07};
	afc_word_t expQ [$];
	int failures, checks;
	afc_output_format_config afc_output_format_config_inst (.clk, .sys_rst,
		.csN, .sck, .sdi, .sdoOut, .sdoOe, .sampleEn, .sampleCh1, .sampleCh2,
		.dataCh1, .dataCh2, .dataOe, .outputStandardSel, .driveCurrentSel,
		.internalTermEn, .currentDouble, .lvdsCurrentQuarterMa, .swResetPulse);
	afc_host_model afc_host_model_inst (.clk, .csN, .sck, .sdi, .sdoOe);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task cmp(input afc_word_t a, input afc_word_t e);
		checks++;
		if (a !== e) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, a, e);
		end
	endtask : cmp
	task end_of_test;
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task wr(input logic [6:0] a, input logic [7:0] d);
		afc_host_model_inst.xfer({1'h0, a, d}, r);
	endtask : wr
	task rdc(input logic [6:0] a, input logic [7:0] e);
		afc_host_model_inst.xfer({1'h1, a, 8'h00}, r);
		cmp({5'h00, r}, {5'h00, e});
	endtask : rdc
	function automatic afc_word_t ex(input logic [5:0] f, input logic ph,
		input afc_word_t s);
		afc_word_t w;
		w = s;
		case (f[5:3])
		3'h1: w = 13'h0000;
		3'h3: w = 13'h1fff;
		3'h5: w = ph ? 13'h0aaa : 13'h1555;
		3'h7: w = ph ? 13'h1fff : 13'h0000;
		default: begin
			w[11] = w[11] ^ (f[0] & ~f[2]);
			if (f[2]) w[11:0] = w[11:0] ^ 12'haaa;
			if (f[1]) w[11:1] = w[11:1] ^ {11{w[0]}};
		end
		endcase
		return w;
	endfunction : ex
	task smp(input logic [5:0] f, input logic ph);
		@(negedge clk);
		sampleEn = 1'h1;
		sampleCh1 = 13'($urandom);
		sampleCh2 = 13'($urandom);
		expQ.push_back(ex(f, ph, sampleCh1));
		expQ.push_back(ex(f, ph, sampleCh2));
		@(negedge clk);
		sampleEn = 1'h0;
	endtask : smp
	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	always @(posedge clk) took <= sampleEn;
	always @(negedge clk) begin
		if (took === 1'h1) begin
			cmp(dataCh1, expQ.pop_front());
			cmp(dataCh2, expQ.pop_front());
		end
	end
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h1363e1b8));
		sys_rst = 1'h1;
		sampleEn = 1'h0;
		sampleCh1 = 13'h0000;
		sampleCh2 = 13'h0000;
		repeat (10) @(negedge clk);
		sys_rst = 1'h0;
		rdc(7'h03, 8'h00);
		rdc(7'h04, 8'h00);
		wr(7'h03, 8'hff);
		rdc(7'h03, 8'h7f);
		wr(7'h04, 8'hff);
		rdc(7'h04, 8'h3f);
		for (int d = 0; d < 8; d++) begin
			if (d != 3) begin
				wr(7'h03, {1'h0, d[2:0], d[0], 1'h0, 2'(d % 3)});
				cmp({lvdsCurrentQuarterMa, dataOe, internalTermEn,
					currentDouble, driveCurrentSel, outputStandardSel},
					{cur[d], 1'h1, d[0], d[0], d[2:0], 2'(d % 3)});
			end
		end
		wr(7'h01, 8'h02);
		wr(7'h03, 8'h04);
		cmp({12'h000, dataOe}, 13'h0000);
		wr(7'h00, 8'h80);
		cmp({12'h000, dataOe}, 13'h0001);
		rdc(7'h04, 8'h00);
		for (int i = 0; i < 8; i++) begin
			if (i > 3) begin
				sys_rst = 1'h1;
				repeat (3) @(negedge clk);
				sys_rst = 1'h0;
			end
			wr(7'h04, {2'h0, tab[i]});
			smp(tab[i], 1'h0);
			smp(tab[i], 1'h1);
		end
		repeat (2) @(negedge clk);
		end_of_test();
	end
endmodule : afc_output_format_config_bench

//--- testbench/afc_output_format_config_chk.sv
`timescale 1ns/1ps
module afc_output_format_config_chk (
	// clock, reset, pins
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic csN,
	input wire logic sdoOut,
	input wire logic sdoOe,
	input wire logic sampleEn,
	// outputs under watch
	input wire afc_pkg::afc_word_t dataCh1,
	input wire afc_pkg::afc_word_t dataCh2,
	input wire logic dataOe,
	input wire afc_pkg::afc_std_t outputStandardSel,
	input wire logic [2:0] driveCurrentSel,
	input wire logic internalTermEn,
	input wire logic currentDouble,
	input wire logic [4:0] lvdsCurrentQuarterMa,
	input wire logic swResetPulse
);
	import afc_pkg::*;
	logic [4:0] qma [8] = '{5'h0e, 5'h10, 5'h12, 5'h00, 5'h0c, 5'h0a, 5'h08,
		5'h07};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_term_double: assert property (currentDouble == internalTermEn)
		else $error("current doubling differs from termination");
	a_current_map: assert property (driveCurrentSel != 3'h3 |->
		lvdsCurrentQuarterMa == qma[driveCurrentSel])
		else $error("drive current code gives wrong current");
	a_sdo_open: assert property (sdoOut == 1'h0)
		else $error("serial output drives high");
	a_sdo_idle: assert property (csN |=> !sdoOe)
		else $error("serial output pulls low between frames");
	a_data_hold: assert property (!$past(sampleEn) |->
		$stable(dataCh1) && $stable(dataCh2))
		else $error("output word changed without a sample");
	a_swrst_clear: assert property ($rose(swResetPulse) |-> ##[0:3]
		(dataOe && !internalTermEn && driveCurrentSel == 3'h0 &&
		outputStandardSel == AFC_STD_CMOS))
		else $error("software reset left settings");
	a_pulse_one: assert property (swResetPulse |=> !swResetPulse)
		else $error("reset pulse longer than one cycle");
	a_frame_quiet: assert property (!csN && !$past(csN) &&
		!$past(csN, 2) |-> $stable({dataOe, driveCurrentSel,
		internalTermEn, outputStandardSel}))
		else $error("setting changed inside a frame");
	a_reset_state: assert property ($past(sys_rst) |-> dataOe &&
		dataCh1 == 13'h0000 && dataCh2 == 13'h0000)
		else $error("wrong state after reset");
endmodule : afc_output_format_config_chk
bind afc_output_format_config afc_output_format_config_chk
	afc_output_format_config_chk_inst (.clk, .sys_rst, .csN, .sdoOut, .sdoOe,
	.sampleEn, .dataCh1, .dataCh2, .dataOe, .outputStandardSel,
	.driveCurrentSel, .internalTermEn, .currentDouble,
	.lvdsCurrentQuarterMa, .swResetPulse);
